// ==== design/lwp_regs.svh ====
// Register offsets, field positions, reset values and timing counts for waveform/power control
`ifndef LWP_REGS_SVH
`define LWP_REGS_SVH

// Instruction indexes
`define LWP_IDX_START_OSC     6'h00
`define LWP_IDX_WAVEFORM      6'h02
`define LWP_IDX_POWER1        6'h03
`define LWP_IDX_POWER2        6'h0c

// Waveform control fields and the start-oscillation bit
`define LWP_WF_ROWS_LSB       0
`define LWP_WF_XOR_BIT        8
`define LWP_WF_ROWMODE_BIT    9
`define LWP_WF_RST_BIT        10
`define LWP_WF_START_BIT      0

// Power control 1 fields
`define LWP_P1_SLP_BIT        0
`define LWP_P1_STB_BIT        1
`define LWP_P1_AP_LSB         2
`define LWP_P1_DC_LSB         4
`define LWP_P1_BT_LSB         8
`define LWP_P1_BS_LSB         12

// Power control 2 fields
`define LWP_P2_TC_LSB         0
`define LWP_P2_RV_BIT         2
`define LWP_P2_VC_LSB         4

// Reset values
`define LWP_WF_RESET          16'h0000
`define LWP_P1_RESET          16'h0000
`define LWP_P2_RESET          16'h0000

// Software reset length in internal clocks
`define LWP_SOFT_RESET_CLKS   4'ha

// Booster clock divider terminal counts, each the division ratio minus one
`define LWP_DIV_32            8'h1f
`define LWP_DIV_64            8'h3f
`define LWP_DIV_96            8'h5f
`define LWP_DIV_128           8'h7f

// Amplifier current codes
`define LWP_AP_OFF            2'h0

`endif

// ==== design/lwp_pkg.sv ====
// Types shared by the waveform/power control block
package lwp_pkg;

    typedef struct packed {
        logic       row_mode;
        logic       xor_en;
        logic [5:0] rows;
    } lwp_wave_t;

    typedef struct packed {
        logic [3:0] drive_bias_sel;
        logic [2:0] pump_gain_sel;
        logic       inverter_run_bit;
        logic [2:0] pump_clock_divider_sel;
        logic [1:0] amp_current_sel;
        logic       standby_bit;
        logic       sleep_bit;
    } lwp_pwr1_t;

    typedef struct packed {
        logic [2:0] input_rail_scale_sel;
        logic       ref_source_sel;
        logic [1:0] temp_slope_sel;
    } lwp_pwr2_t;

    typedef enum logic [1:0] {
        LWP_RUN,
        LWP_SLEEP,
        LWP_STANDBY
    } lwp_mode_t;

endpackage

// ==== design/lwp_pump_div.sv ====
// Programmable divider producing one-cycle pump clock enables
`timescale 1ns/10ps
`default_nettype none

module lwp_pump_div #(
    parameter int W = 8
) (
    // Clock and control
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         run,
    // Terminal count is ratio minus one
    input  wire logic [W-1:0] term,
    // Enable pulse
    output logic              tick
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    wire          at_end = (cnt_q >= term);

    assign cnt_d = (!run || at_end) ? '0 : cnt_q + 1'b1;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= run && at_end;
        end
    end

endmodule

`default_nettype wire

// ==== design/lwp_ctrl.sv ====
// Drive waveform, software reset and power-mode control register bank
//
// Summary of operation
// [R1] Frame polarity reversal when row mode clear
// [R2] Row mode reverses polarity per row group
// [R3] XOR option mixes frame and row signals
// [R4] Soft reset lasts ten clocks, self-clears
// [R5] Host waits ten clocks after soft reset
// [R6] Host avoids soft reset during standby
// [R7] Row group size is count plus one
// [R8] Standby grounds drivers, stops everything
// [R9] Standby keeps memory, accepts only two commands
// [R10] Sleep halts display, oscillator runs
// [R11] Sleep accepts only power-control field writes
// [R12] Bias select picks one of sixteen ratios
// [R13] Amp current code zero disables amplifier
// [R14] Code zero without display stops pumps
// [R15] Divider select sets booster clock rates
// [R16] Gain select sets booster multiplication factors
// [R17] Inverter bit runs or halts inverter
// [R18] Reference select chooses external or internal
// [R19] Temperature slope selects one of four
// [R20] Rail scale code sets booster one input
// [R21] Host waits after oscillator restart
// [R22] Fixed zero waveform bits are ignored
`timescale 1ns/10ps
`default_nettype none
`include "lwp_regs.svh"

module lwp_ctrl #(
    parameter int SRST_CLKS = 10
) (
    // Clock and hardware reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Indexed instruction port
    input  wire logic        wr_stb,
    input  wire logic [5:0]  wr_index,
    input  wire logic [15:0] wr_data,
    // Frame and raster-row timing from the display engine
    input  wire logic        frame_start,
    input  wire logic        row_start,
    input  wire logic        display_on,
    // Display memory access requests from the host side
    input  wire logic        mem_req,
    // Drive state
    output logic             ac_polarity,
    output logic             drivers_grounded,
    output logic             display_run,
    output logic             osc_run,
    output logic             mem_grant,
    output logic             soft_reset_active,
    // Analog settings
    output lwp_pkg::lwp_pwr1_t pwr1,
    output lwp_pkg::lwp_pwr2_t pwr2,
    output logic             amp_enable,
    output logic             pumps_enable,
    output logic             inverter_enable,
    output logic             booster1_clk_en,
    output logic             booster2_clk_en
);

    // ==========================================
    // Registers and decode
    // ==========================================
    lwp_pkg::lwp_wave_t wave_q;
    lwp_pkg::lwp_pwr1_t pwr1_q;
    lwp_pkg::lwp_pwr2_t pwr2_q;
    lwp_pkg::lwp_mode_t mode;
    logic [3:0]         srst_cnt_q;
    logic               osc_halt_q;
    logic               frame_odd_q;
    logic               row_pol_q;
    logic [5:0]         row_cnt_q;

    wire soft_rst   = srst_cnt_q != 4'h0;
    wire any_reset  = reset || soft_rst;
    wire standby    = pwr1_q.standby_bit;
    wire sleeping   = pwr1_q.sleep_bit && !standby;

    assign mode = standby ? lwp_pkg::LWP_STANDBY :
                  sleeping ? lwp_pkg::LWP_SLEEP : lwp_pkg::LWP_RUN;

    // [R9] standby gates writes
    // [R11] sleep gates writes
    wire wr_ok      = wr_stb && !soft_rst;
    wire wr_wave    = wr_ok && wr_index == `LWP_IDX_WAVEFORM && mode == lwp_pkg::LWP_RUN;
    wire wr_p1      = wr_ok && wr_index == `LWP_IDX_POWER1;
    wire wr_p2      = wr_ok && wr_index == `LWP_IDX_POWER2 && mode == lwp_pkg::LWP_RUN;
    wire wr_osc     = wr_ok && wr_index == `LWP_IDX_START_OSC && wr_data[`LWP_WF_START_BIT];
    // [R6] host keeps soft reset out of standby
    wire start_srst = wr_wave && wr_data[`LWP_WF_RST_BIT];

    // Power control 1 in standby: only standby bit may change
    lwp_pkg::lwp_pwr1_t p1_new;
    always_comb begin
        p1_new.sleep_bit              = wr_data[`LWP_P1_SLP_BIT];
        p1_new.standby_bit            = wr_data[`LWP_P1_STB_BIT];
        p1_new.amp_current_sel        = wr_data[`LWP_P1_AP_LSB +: 2];
        p1_new.pump_clock_divider_sel = wr_data[`LWP_P1_DC_LSB +: 3];
        p1_new.inverter_run_bit       = wr_data[`LWP_P1_BT_LSB + 3];
        p1_new.pump_gain_sel          = wr_data[`LWP_P1_BT_LSB +: 3];
        p1_new.drive_bias_sel         = wr_data[`LWP_P1_BS_LSB +: 4];
        if (standby) begin
            p1_new             = pwr1_q;
            p1_new.standby_bit = wr_data[`LWP_P1_STB_BIT];
        end
    end

    // ==========================================
    // Register storage
    // ==========================================
    // [R22] only defined waveform bits stored
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            wave_q <= lwp_pkg::lwp_wave_t'(`LWP_WF_RESET);
        end else if (wr_wave) begin
            wave_q.rows     <= wr_data[`LWP_WF_ROWS_LSB +: 6];
            wave_q.xor_en   <= wr_data[`LWP_WF_XOR_BIT];
            wave_q.row_mode <= wr_data[`LWP_WF_ROWMODE_BIT];
        end
    end

    // Power control 1, filtered by mode in p1_new
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            pwr1_q <= lwp_pkg::lwp_pwr1_t'(`LWP_P1_RESET);
        end else if (wr_p1) begin
            pwr1_q <= p1_new;
        end
    end

    // Power control 2, refused outside run mode
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            pwr2_q <= lwp_pkg::lwp_pwr2_t'(`LWP_P2_RESET);
        end else if (wr_p2) begin
            pwr2_q.temp_slope_sel       <= wr_data[`LWP_P2_TC_LSB +: 2];
            pwr2_q.ref_source_sel       <= wr_data[`LWP_P2_RV_BIT];
            pwr2_q.input_rail_scale_sel <= wr_data[`LWP_P2_VC_LSB +: 3];
        end
    end

    // ==========================================
    // Software reset timer
    // ==========================================
    // [R4] ten-clock reset then self-clear
    // [R5] host holds off during count
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            srst_cnt_q <= 4'h0;
        end else if (start_srst) begin
            srst_cnt_q <= `LWP_SOFT_RESET_CLKS;
        end else if (soft_rst) begin
            srst_cnt_q <= srst_cnt_q - 4'h1;
        end
    end

    // ==========================================
    // Oscillator halt
    // ==========================================
    // [R8] standby halts oscillator
    // [R21] restart command leaves halt
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            osc_halt_q <= 1'b0;
        end else if (wr_osc) begin
            osc_halt_q <= 1'b0;
        end else if (wr_p1 && p1_new.standby_bit && !standby) begin
            osc_halt_q <= 1'b1;
        end
    end

    // ==========================================
    // AC alternation
    // ==========================================
    wire disp_active = mode == lwp_pkg::LWP_RUN;
    // [R7] group of count plus one rows
    wire row_wrap    = row_cnt_q == wave_q.rows;

    // [R1] frame toggle
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            frame_odd_q <= 1'b0;
        end else if (disp_active && frame_start) begin
            frame_odd_q <= !frame_odd_q;
        end
    end

    // [R2] row group reversal
    // Counter restarts each frame; polarity carries over
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            row_pol_q <= 1'b0;
            row_cnt_q <= 6'h00;
        end else if (disp_active) begin
            if (frame_start) begin
                row_cnt_q <= 6'h00;
            end else if (row_start) begin
                row_cnt_q <= row_wrap ? 6'h00 : row_cnt_q + 6'h01;
                if (row_wrap) begin
                    row_pol_q <= !row_pol_q;
                end
            end
        end
    end

    // [R3] optional XOR of frame and row signals
    wire c_pol    = wave_q.xor_en ? (frame_odd_q ^ row_pol_q) : row_pol_q;
    wire pol_next = wave_q.row_mode ? c_pol : frame_odd_q;

    // ==========================================
    // Pump clock enables
    // ==========================================
    // [R15] divider selection
    wire [7:0] b1_term = pwr1_q.pump_clock_divider_sel[0] ? `LWP_DIV_64 : `LWP_DIV_32;
    logic [7:0] b2_term;
    always_comb begin
        case (pwr1_q.pump_clock_divider_sel[2:1])
            2'h0:    b2_term = `LWP_DIV_32;
            2'h1:    b2_term = `LWP_DIV_64;
            2'h2:    b2_term = `LWP_DIV_96;
            default: b2_term = `LWP_DIV_128;
        endcase
    end

    // [R13] amplifier off at code zero
    wire amp_on   = pwr1_q.amp_current_sel != `LWP_AP_OFF && !standby;
    // [R14] pumps stop with amp off and no display
    wire pumps_on = !standby && (amp_on || (display_on && disp_active));
    wire b1_tick;
    wire b2_tick;

    lwp_pump_div #(.W(8)) u_div_b1 (
        .clk_sys (clk_sys),
        .reset   (any_reset),
        .run     (pumps_on),
        .term    (b1_term),
        .tick    (b1_tick)
    );

    lwp_pump_div #(.W(8)) u_div_b2 (
        .clk_sys (clk_sys),
        .reset   (any_reset),
        .run     (pumps_on),
        .term    (b2_term),
        .tick    (b2_tick)
    );

    // ==========================================
    // Registered outputs
    // ==========================================
    // [R8] drivers to ground in standby or sleep
    wire grounded_d = !disp_active || !display_on;
    // [R10] sleep halts display, oscillator runs
    wire run_d      = disp_active;
    wire osc_d      = !(standby && osc_halt_q);
    // [R9] memory refused in standby; [R11] also in sleep
    wire grant_d    = mem_req && disp_active && !soft_rst;
    // [R17] inverter gate
    wire inverter_d = pwr1_q.inverter_run_bit && pumps_on;

    // Polarity and soft reset status
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ac_polarity       <= 1'b0;
            soft_reset_active <= 1'b0;
        end else begin
            ac_polarity       <= pol_next;
            soft_reset_active <= soft_rst;
        end
    end

    // Driver and memory gating; drivers grounded out of reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drivers_grounded <= 1'b1;
            display_run      <= 1'b0;
            osc_run          <= 1'b1;
            mem_grant        <= 1'b0;
        end else begin
            drivers_grounded <= grounded_d;
            display_run      <= run_d;
            osc_run          <= osc_d;
            mem_grant        <= grant_d;
        end
    end

    // [R12] bias, [R16] gains, [R19] slope, [R20] rail scale
    // [R18] reference source passed to analog
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pwr1 <= lwp_pkg::lwp_pwr1_t'(`LWP_P1_RESET);
            pwr2 <= lwp_pkg::lwp_pwr2_t'(`LWP_P2_RESET);
        end else begin
            pwr1 <= pwr1_q;
            pwr2 <= pwr2_q;
        end
    end

    // Analog block enables
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            amp_enable      <= 1'b0;
            pumps_enable    <= 1'b0;
            inverter_enable <= 1'b0;
        end else begin
            amp_enable      <= amp_on;
            pumps_enable    <= pumps_on;
            inverter_enable <= inverter_d;
        end
    end

    // Pump clock enables, one cycle each
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            booster1_clk_en <= 1'b0;
            booster2_clk_en <= 1'b0;
        end else begin
            booster1_clk_en <= b1_tick;
            booster2_clk_en <= b2_tick;
        end
    end

endmodule

`default_nettype wire

// ==== tb/lwp_host_model.sv ====
// Host model driving the indexed write port
`timescale 1ns/10ps
`default_nettype none
`include "lwp_regs.svh"

module lwp_host_model #(
    // Oscillator settle wait, shortened from the real settling time
    parameter int OSC_WAIT = 50
) (
    // Clock
    input  wire logic   clk_sys,
    // Write port
    output logic        wr_stb,
    output logic [5:0]  wr_index,
    output logic [15:0] wr_data
);
    int   hold;
    logic in_stb;

    initial begin
        wr_stb = 1'b0;
        wr_index = 6'h00;
        wr_data = 16'h0000;
        hold = 0;
        in_stb = 1'b0;
    end

    task automatic write(input logic [5:0] idx, input logic [15:0] dat);
        while (hold > 0) begin
            @(posedge clk_sys);
            hold--;
        end
        if (idx == `LWP_IDX_WAVEFORM && in_stb)
            dat[`LWP_WF_RST_BIT] = 1'b0;
        wr_stb = 1'b1;
        wr_index = idx;
        wr_data = dat;
        @(posedge clk_sys);
        #1;
        wr_stb = 1'b0;
        wr_data = ~dat;
        @(posedge clk_sys);
        #1;
        if (idx == `LWP_IDX_POWER1)
            in_stb = dat[`LWP_P1_STB_BIT];
        if (idx == `LWP_IDX_WAVEFORM && dat[`LWP_WF_RST_BIT])
            hold = 12;
        if (idx == `LWP_IDX_START_OSC)
            hold = OSC_WAIT;
    endtask
endmodule
`default_nettype wire

// ==== tb/lwp_ctrl_properties.sv ====
// Port-level checks of the control block
`timescale 1ns/10ps
`default_nettype none
`include "lwp_regs.svh"

module lwp_ctrl_checker #(
    parameter int SRST_CLKS = 10
) (
    // Clock, reset, host port
    input wire logic               clk_sys,
    input wire logic               reset,
    input wire logic               wr_stb,
    input wire logic [5:0]         wr_index,
    input wire logic [15:0]        wr_data,
    input wire logic               display_on,
    // Observed outputs
    input wire logic               display_run,
    input wire logic               drivers_grounded,
    input wire logic               osc_run,
    input wire logic               mem_grant,
    input wire logic               soft_reset_active,
    input wire logic               amp_enable,
    input wire logic               pumps_enable,
    input wire lwp_pkg::lwp_pwr1_t pwr1,
    input wire lwp_pkg::lwp_pwr2_t pwr2
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ====
    // Soft reset length counter
    int unsigned srst_q;
    always_ff @(posedge clk_sys) begin
        if (reset || !soft_reset_active)
            srst_q <= 0;
        else
            srst_q <= srst_q + 1;
    end

    AST_SRST_GO: assert property (
        wr_stb && !$past(wr_stb) && wr_index == `LWP_IDX_WAVEFORM && wr_data[`LWP_WF_RST_BIT]
            && display_run && !soft_reset_active |-> ##[1:2] soft_reset_active)
        else $error("soft reset did not start");
    AST_SRST_LEN: assert property ($fell(soft_reset_active) |-> srst_q == SRST_CLKS)
        else $error("soft reset length wrong");
    AST_SRST_MAX: assert property (soft_reset_active |-> srst_q < SRST_CLKS)
        else $error("soft reset overran");
    AST_STB_QUIET: assert property (
        pwr1.standby_bit && $past(pwr1.standby_bit) |-> drivers_grounded && !display_run
            && !mem_grant)
        else $error("standby not quiet");
    AST_SLP_OSC: assert property (
        pwr1.sleep_bit && $past(pwr1.sleep_bit) && !pwr1.standby_bit |-> osc_run && !display_run)
        else $error("sleep mode wrong");
    AST_SLP_PWR2: assert property (
        pwr1.sleep_bit && !$past(wr_stb) && wr_stb && wr_index == `LWP_IDX_POWER2
            |-> ##2 pwr2 == $past(pwr2, 2))
        else $error("power2 written in sleep");
    AST_AMP_OFF: assert property (
        pwr1.amp_current_sel == `LWP_AP_OFF && $past(pwr1.amp_current_sel) == `LWP_AP_OFF
            |-> !amp_enable)
        else $error("amplifier on at code zero");
    AST_PUMP_OFF: assert property (
        pwr1.amp_current_sel == `LWP_AP_OFF && $past(pwr1.amp_current_sel) == `LWP_AP_OFF
            && !display_on && !$past(display_on) |-> !pumps_enable)
        else $error("pumps on while idle");
endmodule

bind lwp_ctrl lwp_ctrl_checker #(.SRST_CLKS(SRST_CLKS)) chk (.clk_sys, .reset, .wr_stb,
    .wr_index, .wr_data, .display_on, .display_run, .drivers_grounded, .osc_run, .mem_grant,
    .soft_reset_active, .amp_enable, .pumps_enable, .pwr1, .pwr2);
`default_nettype wire

// ==== tb/tb_lwp_ctrl.sv ====
// Self-checking bench for the waveform and power control block
`timescale 1ns/10ps
`default_nettype none
`include "lwp_regs.svh"

`define CHK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
        errors++; \
        $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
end

module tb_lwp_ctrl;
    // ====
    // Signals
    logic               clk_sys, reset, frame_start, row_start, display_on, mem_req, p;
    logic               wr_stb, ac_polarity, drivers_grounded, display_run, osc_run;
    logic               mem_grant, soft_reset_active, amp_enable, pumps_enable;
    logic               inverter_enable, booster1_clk_en, booster2_clk_en;
    logic [5:0]         wr_index;
    logic [15:0]        wr_data;
    lwp_pkg::lwp_pwr1_t pwr1, v;
    lwp_pkg::lwp_pwr2_t pwr2, v2;
    int                 errors, tests_run, n, k;
    int                 sz[3] = '{1, 3, 64};

    lwp_ctrl uut (.clk_sys, .reset, .wr_stb, .wr_index, .wr_data, .frame_start, .row_start,
        .display_on, .mem_req, .ac_polarity, .drivers_grounded, .display_run, .osc_run,
        .mem_grant, .soft_reset_active, .pwr1, .pwr2, .amp_enable, .pumps_enable,
        .inverter_enable, .booster1_clk_en, .booster2_clk_en);
    lwp_host_model #(.OSC_WAIT(50)) host (.clk_sys, .wr_stb, .wr_index, .wr_data);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ====
    // Helpers
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [5:0] i, input logic [15:0] d);
        host.write(i, d);
        cyc(2);
    endtask
    task automatic p1(input lwp_pkg::lwp_pwr1_t s);
        wr(`LWP_IDX_POWER1, {s.drive_bias_sel, s.inverter_run_bit, s.pump_gain_sel, 1'b0,
            s.pump_clock_divider_sel, s.amp_current_sel, s.standby_bit, s.sleep_bit});
    endtask
    task automatic fr();
        frame_start = 1'b1;
        cyc(1);
        frame_start = 1'b0;
        cyc(2);
    endtask
    task automatic rows(input int r, output int ch);
        ch = 0;
        repeat (r) begin
            p = ac_polarity;
            row_start = 1'b1;
            cyc(1);
            row_start = 1'b0;
            cyc(2);
            if (ac_polarity !== p)
                ch++;
        end
    endtask
    function automatic logic pb(input int w);
        return w ? booster2_clk_en : booster1_clk_en;
    endfunction
    task automatic period(input int w, output int c);
        for (c = 0; c < 300 && pb(w) !== 1'b1; c++)
            cyc(1);
        c = 0;
        do begin
            cyc(1);
            c++;
        end while (c < 300 && pb(w) !== 1'b1);
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #1ms;
        errors++;
        conclude();
    end

    // ====
    // Tests
    initial begin
        {reset, frame_start, row_start, display_on, mem_req} = 5'h10;
        errors = 0;
        tests_run = 0;
        cyc(6);
        `CHK("pwr1", 15'h0000, pwr1)
        `CHK("pwr2", 6'h00, pwr2)
        `CHK("grounded", 1'b1, drivers_grounded)
        `CHK("osc", 1'b1, osc_run)
        reset = 1'b0;
        $display("Test reset done");
        for (k = 0; k < 6; k++) begin
            v = '0;
            v.drive_bias_sel = 4'(k * 3);
            v.pump_gain_sel = 3'(k);
            v.inverter_run_bit = k[0];
            v.amp_current_sel = k[1:0];
            p1(v);
            `CHK("pwr1", v, pwr1)
            `CHK("amp", k[1:0] != 0, amp_enable)
            `CHK("pumps", k[1:0] != 0, pumps_enable)
            `CHK("inv", k[0], inverter_enable)
        end
        display_on = 1'b1;
        for (k = 0; k < 8; k++) begin
            v = '0;
            v.amp_current_sel = 2'h1;
            v.pump_clock_divider_sel = 3'(k);
            p1(v);
            period(0, n);
            `CHK("b1 period", k[0] ? 64 : 32, n)
            period(1, n);
            `CHK("b2 period", 32 * (k[2:1] + 1), n)
        end
        for (k = 0; k < 4; k++) begin
            v2 = {3'(k % 3), k[0], k[1:0]};
            wr(`LWP_IDX_POWER2, {9'h000, v2.input_rail_scale_sel, 1'b0, v2.ref_source_sel,
                v2.temp_slope_sel});
            `CHK("pwr2", v2, pwr2)
        end
        $display("Test fields done");
        v.sleep_bit = 1'b1;
        mem_req = 1'b1;
        p1(v);
        `CHK("run", 1'b0, display_run)
        `CHK("osc", 1'b1, osc_run)
        `CHK("grant", 1'b0, mem_grant)
        wr(`LWP_IDX_POWER2, 16'h0077);
        `CHK("pwr2", v2, pwr2)
        v.drive_bias_sel = 4'h9;
        p1(v);
        `CHK("pwr1", v, pwr1)
        v.sleep_bit = 1'b0;
        p1(v);
        `CHK("grant", 1'b1, mem_grant)
        v.standby_bit = 1'b1;
        p1(v);
        `CHK("grounded", 1'b1, drivers_grounded)
        `CHK("run", 1'b0, display_run)
        `CHK("osc", 1'b0, osc_run)
        `CHK("grant", 1'b0, mem_grant)
        v.drive_bias_sel = 4'h3;
        p1(v);
        v.drive_bias_sel = 4'h9;
        `CHK("pwr1", v, pwr1)
        wr(`LWP_IDX_START_OSC, 16'h0001);
        `CHK("osc", 1'b1, osc_run)
        v.standby_bit = 1'b0;
        p1(v);
        `CHK("run", 1'b1, display_run)
        mem_req = 1'b0;
        $display("Test modes done");
        wr(`LWP_IDX_WAVEFORM, 16'h0000);
        repeat (2) begin
            p = ac_polarity;
            fr();
            `CHK("frame ac", ~p, ac_polarity)
        end
        foreach (sz[i]) begin
            wr(`LWP_IDX_WAVEFORM, 16'hfac0 | 16'(sz[i] - 1));
            fr();
            rows(2 * sz[i], n);
            `CHK("row flips", 2, n)
        end
        for (k = 0; k < 2; k++) begin
            wr(`LWP_IDX_WAVEFORM, 16'h0202 | 16'(k << 8));
            p = ac_polarity;
            fr();
            `CHK("xor frame", p ^ k[0], ac_polarity)
        end
        $display("Test waveform done");
        host.write(`LWP_IDX_WAVEFORM, 16'h0400);
        for (n = 0; n < 5 && soft_reset_active !== 1'b1; n++)
            cyc(1);
        for (n = 0; n < 50 && soft_reset_active === 1'b1; n++)
            cyc(1);
        `CHK("srst len", `LWP_SOFT_RESET_CLKS, n)
        `CHK("pwr1", 15'h0000, pwr1)
        `CHK("pwr2", 6'h00, pwr2)
        $display("Test soft reset done");
        conclude();
    end
endmodule
`default_nettype wire
